// [pkg/tcd_cmd_map.vh]
// constants of the tag command dispatcher: codes, results, states, masks
`ifndef TCD_CMD_MAP_VH
`define TCD_CMD_MAP_VH

// command codes
`define TCD_CMD_NOP        8'h00
`define TCD_CMD_GET_UID    8'h01
`define TCD_CMD_RD_BLK     8'h02
`define TCD_CMD_WR_BLK     8'h03
`define TCD_CMD_RD_DBLK    8'h04
`define TCD_CMD_WR_DBLK    8'h05
`define TCD_CMD_RD_PAGE    8'h06
`define TCD_CMD_WR_PAGE    8'h07
`define TCD_CMD_ENCRYPT    8'h08
`define TCD_CMD_DECRYPT    8'h09
`define TCD_CMD_RD_VAL     8'h0a
`define TCD_CMD_WR_VAL     8'h0b
`define TCD_CMD_INC_VAL    8'h0c
`define TCD_CMD_DEC_VAL    8'h0d
`define TCD_CMD_RESTORE    8'h0e
`define TCD_CMD_TRANSFER   8'h0f
`define TCD_CMD_RECOVER    8'h10
`define TCD_CMD_GET_VER    8'h11
`define TCD_CMD_RD_SIG     8'h12
`define TCD_CMD_CFG_UID    8'h13
`define TCD_CMD_RD_CNT     8'h14
`define TCD_CMD_INC_CNT    8'h15
`define TCD_CMD_TEAR       8'h16
`define TCD_CMD_PWD_AUTH   8'h17
`define TCD_CMD_HALT       8'h18
`define TCD_CMD_CRC        8'h19
`define TCD_CMD_COPY       8'h1a
`define TCD_CMD_UNLOCK     8'h1b
`define TCD_CMD_LOCK       8'h1c
`define TCD_CMD_MOD_VER    8'h1d
`define TCD_CMD_DEFAULTS   8'h1e

// outcome codes
`define TCD_RES_OK         8'h00
`define TCD_RES_BAD_CMD    8'h01
`define TCD_RES_BAD_PWD    8'h02

// memory region mask bit positions and mask width
`define TCD_RGN_RESULT     0
`define TCD_RGN_TAG_TYPE   1
`define TCD_RGN_UID        2
`define TCD_RGN_UID_SIZE   3
`define TCD_RGN_BUFFER     4
`define TCD_RGN_NVM        5
`define TCD_RGN_ALL        6
`define TCD_RGN_W          7

// dispatcher states
`define TCD_ST_IDLE        2'h0
`define TCD_ST_DECODE      2'h1
`define TCD_ST_WAIT        2'h2
`define TCD_ST_FINISH      2'h3

// bus selection
`define TCD_BUS_I2C        1'b0
`define TCD_BUS_SPI        1'b1

`endif

// [logic/tcd_cmd_decode.v]
// command code decoder: validity, target regions and execution class
`timescale 1ns/1ps
`include "tcd_cmd_map.vh"

module tcd_cmd_decode (
  // code in
  input  wire [7:0]             code_in,
  // decode out
  output reg                    valid_out,
  output reg                    engine_out,
  output reg                    unlock_out,
  output reg                    lock_out,
  output reg  [`TCD_RGN_W-1:0]  rgn_mask_out
);

  always @* begin
    valid_out    = 1'b1;
    engine_out   = 1'b1;
    unlock_out   = 1'b0;
    lock_out     = 1'b0;
    rgn_mask_out = {`TCD_RGN_W{1'b0}};
    rgn_mask_out[`TCD_RGN_RESULT] = 1'b1;
    case (code_in)
      `TCD_CMD_NOP: begin
        engine_out = 1'b0;
      end
      `TCD_CMD_GET_UID: begin
        rgn_mask_out[`TCD_RGN_TAG_TYPE] = 1'b1; // RULE_06
        rgn_mask_out[`TCD_RGN_UID]      = 1'b1; // RULE_06
        rgn_mask_out[`TCD_RGN_UID_SIZE] = 1'b1; // RULE_06
      end
      `TCD_CMD_RD_BLK, `TCD_CMD_RD_DBLK, `TCD_CMD_RD_PAGE, `TCD_CMD_ENCRYPT,
      `TCD_CMD_DECRYPT, `TCD_CMD_RD_VAL, `TCD_CMD_GET_VER, `TCD_CMD_RD_SIG,
      `TCD_CMD_RD_CNT, `TCD_CMD_TEAR, `TCD_CMD_PWD_AUTH: begin
        rgn_mask_out[`TCD_RGN_BUFFER] = 1'b1; // RULE_07 RULE_09 RULE_10 RULE_15 RULE_16
      end
      `TCD_CMD_WR_BLK, `TCD_CMD_WR_DBLK, `TCD_CMD_WR_PAGE, `TCD_CMD_WR_VAL,
      `TCD_CMD_INC_VAL, `TCD_CMD_DEC_VAL, `TCD_CMD_RESTORE, `TCD_CMD_TRANSFER,
      `TCD_CMD_RECOVER, `TCD_CMD_CFG_UID, `TCD_CMD_INC_CNT, `TCD_CMD_HALT: begin
        rgn_mask_out[`TCD_RGN_RESULT] = 1'b1; // RULE_08 RULE_11 RULE_12 RULE_13 RULE_14
      end
      `TCD_CMD_CRC: begin
        rgn_mask_out[`TCD_RGN_RESULT] = 1'b0; // RULE_17
        rgn_mask_out[`TCD_RGN_BUFFER] = 1'b1; // RULE_17
      end
      `TCD_CMD_COPY, `TCD_CMD_DEFAULTS: begin
        rgn_mask_out[`TCD_RGN_ALL] = 1'b1; // RULE_18
      end
      `TCD_CMD_MOD_VER: begin
        rgn_mask_out[`TCD_RGN_RESULT] = 1'b0;
        rgn_mask_out[`TCD_RGN_BUFFER] = 1'b1;
      end
      `TCD_CMD_UNLOCK: begin
        engine_out = 1'b0;
        unlock_out = 1'b1; // RULE_19
      end
      `TCD_CMD_LOCK: begin
        engine_out = 1'b0;
        lock_out   = 1'b1; // RULE_19
        rgn_mask_out[`TCD_RGN_NVM] = 1'b1; // RULE_19
      end
      default: begin
        valid_out  = 1'b0; // RULE_25
        engine_out = 1'b0;
      end
    endcase
  end

endmodule // tcd_cmd_decode

// [logic/tcd_dispatch.v]
// tag command dispatcher: command capture, transaction end, busy, result
`timescale 1ns/1ps
`include "tcd_cmd_map.vh"
//
// Contract
// [RULE_01] a host write to the command register requests that command
// [RULE_02] on i2c, execution starts only after the stop condition
// [RULE_03] on spi, chip select rising edge ends the transaction and starts execution
// [RULE_04] busy line goes low while parsing registers and executing commands
// [RULE_05] outcome code written to result register after every executed command
// [RULE_06] code 01 updates result, tag type, identifier and identifier size
// [RULE_07] codes 02 and 04 read blocks into buffer, update result
// [RULE_08] codes 03 and 05 write blocks, modify only result
// [RULE_09] codes 06 and 07 read or write pages; read updates buffer
// [RULE_10] codes 08 and 09 encrypt or decrypt buffer in place, update result
// [RULE_11] code 0b writes value block, modifies only result
// [RULE_12] codes 0c and 0d increment or decrement value block, result only
// [RULE_13] codes 0e 0f 10 restore, transfer, recover; result only
// [RULE_14] code 13 configures identifier kind, result only
// [RULE_15] code 15 increments counter; 14 and 16 read counter or tearing
// [RULE_16] code 17 authenticates by password, reply into buffer, result updated
// [RULE_17] code 19 computes checksum into buffer at given offset
// [RULE_18] code 1a copies bytes between any module memory addresses
// [RULE_19] code 1b unlocks by password; 1c relocks and commits to storage
// [RULE_20] code 01 probes field; no tag gives no-tag type, else identifier
// [RULE_21] host issues identifier command before any other tag command
// [RULE_22] host reissues identifier command after any failed tag operation
// [RULE_23] while locked, host access to protected regions is denied
// [RULE_24] new unlock password takes effect only after lock executes
// [RULE_25] undefined code rejected without side effects, error result written
// [RULE_26] busy returns high after result update; command writes ignored meanwhile

module tcd_dispatch #(
  parameter        UID_W      = 80,
  parameter        UID_SIZE_W = 8,
  parameter        PWD_W      = 64,
  parameter [7:0]  NO_TAG_TYPE = 8'h00
) (
  // clock and reset
  input  wire                    clk_in,
  input  wire                    rst_b_in,
  // host register front end
  input  wire                    bus_sel_in,
  input  wire                    cmd_wr_in,
  input  wire [7:0]              cmd_data_in,
  input  wire                    i2c_stop_in,
  input  wire                    spi_cs_b_in,
  // password register access
  input  wire                    pwd_wr_in,
  input  wire [PWD_W-1:0]        pwd_data_in,
  input  wire [PWD_W-1:0]        unlock_pwd_in,
  // protected region access check
  input  wire                    prot_acc_in,
  output wire                    prot_deny_out,
  output wire                    locked_out,
  // operation engine
  output reg                     op_req_out,
  output reg  [7:0]              op_code_out,
  input  wire                    op_done_in,
  input  wire [7:0]              op_status_in,
  input  wire                    tag_present_in,
  input  wire [7:0]              tag_type_in,
  input  wire [UID_W-1:0]        tag_uid_in,
  input  wire [UID_SIZE_W-1:0]   tag_uid_size_in,
  // module registers
  output reg  [7:0]              result_out,
  output reg  [7:0]              tag_type_out,
  output reg  [UID_W-1:0]        tag_uid_out,
  output reg  [UID_SIZE_W-1:0]   tag_uid_size_out,
  output reg  [`TCD_RGN_W-1:0]   rgn_wr_out,
  output reg                     nvm_commit_out,
  output reg  [PWD_W-1:0]        pwd_active_out,
  // status pin
  output reg                     module_busy_low_out
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  reg                   cs_meta_q;
  reg                   cs_sync_q;
  reg                   cs_last_q;
  reg  [1:0]            state_q;
  reg  [1:0]            state_d;
  reg                   pend_q;
  reg  [7:0]            pend_code_q;
  reg  [7:0]            exec_code_q;
  reg                   exec_cmd_q;
  reg                   locked_q;
  reg  [PWD_W-1:0]      pwd_pend_q;
  wire                  cs_rise;
  wire                  xfer_end;
  wire                  dec_valid;
  wire                  dec_engine;
  wire                  dec_unlock;
  wire                  dec_lock;
  wire [`TCD_RGN_W-1:0] dec_mask;

  ////////////////////////////////////////////////////////////////////////////
  // chip select synchroniser and transaction end
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_last_q <= 1'b1;
    end else begin
      cs_meta_q <= spi_cs_b_in;
      cs_sync_q <= cs_meta_q;
      cs_last_q <= cs_sync_q;
    end
  end

  assign cs_rise  = cs_sync_q & ~cs_last_q; // RULE_03
  assign xfer_end = (bus_sel_in == `TCD_BUS_SPI) ? cs_rise : i2c_stop_in; // RULE_02 RULE_03

  ////////////////////////////////////////////////////////////////////////////
  // decoder
  tcd_cmd_decode u_decode (
    .code_in      (exec_code_q),
    .valid_out    (dec_valid),
    .engine_out   (dec_engine),
    .unlock_out   (dec_unlock),
    .lock_out     (dec_lock),
    .rgn_mask_out (dec_mask)
  );

  ////////////////////////////////////////////////////////////////////////////
  // lock control
  assign locked_out    = locked_q;
  assign prot_deny_out = prot_acc_in & locked_q; // RULE_23

  ////////////////////////////////////////////////////////////////////////////
  // state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      `TCD_ST_IDLE: begin
        if (xfer_end) begin
          state_d = `TCD_ST_DECODE; // RULE_04
        end
      end
      `TCD_ST_DECODE: begin
        if (exec_cmd_q && dec_engine) begin
          state_d = `TCD_ST_WAIT;
        end else begin
          state_d = `TCD_ST_FINISH;
        end
      end
      `TCD_ST_WAIT: begin
        if (op_done_in) begin
          state_d = `TCD_ST_FINISH;
        end
      end
      `TCD_ST_FINISH: begin
        state_d = `TCD_ST_IDLE; // RULE_26
      end
      default: begin
        state_d = `TCD_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q             <= `TCD_ST_IDLE;
      pend_q              <= 1'b0;
      pend_code_q         <= `TCD_CMD_NOP;
      exec_code_q         <= `TCD_CMD_NOP;
      exec_cmd_q          <= 1'b0;
      locked_q            <= 1'b1;
      pwd_pend_q          <= {PWD_W{1'b0}};
      pwd_active_out      <= {PWD_W{1'b0}};
      op_req_out          <= 1'b0;
      op_code_out         <= `TCD_CMD_NOP;
      result_out          <= `TCD_RES_OK;
      tag_type_out        <= NO_TAG_TYPE;
      tag_uid_out         <= {UID_W{1'b0}};
      tag_uid_size_out    <= {UID_SIZE_W{1'b0}};
      rgn_wr_out          <= {`TCD_RGN_W{1'b0}};
      nvm_commit_out      <= 1'b0;
      module_busy_low_out <= 1'b1;
    end else begin
      state_q        <= state_d;
      op_req_out     <= 1'b0;
      rgn_wr_out     <= {`TCD_RGN_W{1'b0}};
      nvm_commit_out <= 1'b0;
      module_busy_low_out <= ~(state_d != `TCD_ST_IDLE); // RULE_04 RULE_26
      // command capture only while idle
      if (state_q == `TCD_ST_IDLE && cmd_wr_in) begin
        pend_q      <= 1'b1; // RULE_01 RULE_26
        pend_code_q <= cmd_data_in; // RULE_01
      end
      // password change held pending while unlocked
      if (pwd_wr_in && !locked_q) begin
        pwd_pend_q <= pwd_data_in; // RULE_24
      end
      case (state_q)
        `TCD_ST_IDLE: begin
          if (xfer_end) begin
            exec_cmd_q  <= pend_q | cmd_wr_in; // RULE_02 RULE_03
            exec_code_q <= cmd_wr_in ? cmd_data_in : pend_code_q;
            pend_q      <= 1'b0;
          end
        end
        `TCD_ST_DECODE: begin
          if (exec_cmd_q && dec_engine) begin
            op_req_out  <= 1'b1;
            op_code_out <= exec_code_q;
          end
        end
        `TCD_ST_WAIT: begin
          if (op_done_in) begin
            result_out <= op_status_in; // RULE_05
            rgn_wr_out <= dec_mask; // RULE_07 RULE_09 RULE_10 RULE_16 RULE_17 RULE_18
            if (exec_code_q == `TCD_CMD_GET_UID) begin
              if (tag_present_in) begin
                tag_type_out     <= tag_type_in; // RULE_20
                tag_uid_out      <= tag_uid_in; // RULE_06
                tag_uid_size_out <= tag_uid_size_in; // RULE_06
              end else begin
                tag_type_out     <= NO_TAG_TYPE; // RULE_20
                tag_uid_size_out <= {UID_SIZE_W{1'b0}};
              end
            end
          end
        end
        `TCD_ST_FINISH: begin
          exec_cmd_q <= 1'b0;
          if (exec_cmd_q && !dec_engine) begin
            rgn_wr_out[`TCD_RGN_RESULT] <= 1'b1; // RULE_05
            if (!dec_valid) begin
              result_out <= `TCD_RES_BAD_CMD; // RULE_25
            end else if (dec_unlock) begin
              if (unlock_pwd_in == pwd_active_out) begin
                locked_q   <= 1'b0; // RULE_19
                result_out <= `TCD_RES_OK;
              end else begin
                result_out <= `TCD_RES_BAD_PWD; // RULE_19
              end
            end else if (dec_lock) begin
              locked_q       <= 1'b1; // RULE_19
              pwd_active_out <= pwd_pend_q; // RULE_24
              nvm_commit_out <= 1'b1; // RULE_19
              rgn_wr_out     <= dec_mask;
              result_out     <= `TCD_RES_OK;
            end else begin
              result_out <= `TCD_RES_OK;
            end
          end
        end
        default: begin
          exec_cmd_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // tcd_dispatch

// [dv/tcd_dispatch_monitor.sv]
// assertions on the tag command dispatcher ports
`timescale 1ns/1ps
module tcd_dispatch_monitor #(
  parameter [7:0] NO_TAG_TYPE = 8'h00
) (
  input wire       clk_in,
  input wire       rst_b_in,
  input wire       bus_sel_in,
  input wire       i2c_stop_in,
  input wire       spi_cs_b_in,
  input wire       prot_acc_in,
  input wire       prot_deny_out,
  input wire       locked_out,
  input wire       op_req_out,
  input wire [7:0] op_code_out,
  input wire       op_done_in,
  input wire [7:0] op_status_in,
  input wire       tag_present_in,
  input wire [7:0] tag_type_in,
  input wire [7:0] result_out,
  input wire [7:0] tag_type_out,
  input wire [6:0] rgn_wr_out,
  input wire       module_busy_low_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire idle = module_busy_low_out;
  wire fin  = op_done_in && !idle;
  ////////////////////////////////////////////////////////////////////////////////
  chk_i2c_end_busy:
    assert property (!bus_sel_in && i2c_stop_in && idle |=> !idle)
      else $error("no busy after stop");
  chk_i2c_no_end:
    assert property (!bus_sel_in && !i2c_stop_in && idle |=> idle)
      else $error("busy without stop");
  chk_spi_end_busy:
    assert property (bus_sel_in && idle && $rose(spi_cs_b_in) |-> ##[2:5] !idle)
      else $error("no busy after chip select rise");
  chk_busy_min:
    assert property ($fell(idle) |-> !idle [*2]) else $error("busy pulse too short");
  chk_req_busy:
    assert property (op_req_out |-> !idle && !$past(idle)) else $error("request while idle");
  chk_result_load:
    assert property (fin |=> result_out == $past(op_status_in)) else $error("result not loaded");
  chk_busy_release:
    assert property (fin |=> !idle ##1 idle) else $error("busy release off");
  chk_uid_type:
    assert property (fin && op_code_out == 8'h01 |=> rgn_wr_out == 7'h0f &&
      tag_type_out == ($past(tag_present_in) ? $past(tag_type_in) : NO_TAG_TYPE))
      else $error("tag type wrong");
  chk_deny_lock:
    assert property (prot_deny_out == (prot_acc_in && locked_out)) else $error("deny wrong");
  cover property (fin && op_code_out == 8'h01);
  cover property (bus_sel_in && $rose(spi_cs_b_in));
  cover property (prot_deny_out);
endmodule // tcd_dispatch_monitor

bind tcd_dispatch tcd_dispatch_monitor #(.NO_TAG_TYPE(NO_TAG_TYPE)) tcd_dispatch_monitor_inst (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .bus_sel_in(bus_sel_in), .i2c_stop_in(i2c_stop_in),
  .spi_cs_b_in(spi_cs_b_in), .prot_acc_in(prot_acc_in), .prot_deny_out(prot_deny_out),
  .locked_out(locked_out), .op_req_out(op_req_out), .op_code_out(op_code_out),
  .op_done_in(op_done_in), .op_status_in(op_status_in), .tag_present_in(tag_present_in),
  .tag_type_in(tag_type_in), .result_out(result_out), .tag_type_out(tag_type_out),
  .rgn_wr_out(rgn_wr_out), .module_busy_low_out(module_busy_low_out));

// [dv/tcd_engine_model.sv]
// behavioural operation engine answering dispatcher requests
`timescale 1ns/1ps
module tcd_engine_model (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_b_in,
  // request and answer settings
  input  wire        op_req_in,
  input  wire [3:0]  lat_in,
  input  wire [7:0]  status_in,
  input  wire        present_in,
  // answer
  output reg         op_done_out,
  output wire [7:0]  op_status_out,
  output wire        tag_present_out,
  output wire [7:0]  tag_type_out,
  output wire [79:0] tag_uid_out,
  output wire [7:0]  tag_uid_size_out
);
  reg [3:0] cnt_q;
  reg       run_q;
  // answer fields valid only with done; inverted otherwise, except tag type, which then drops its a5 mask
  assign op_status_out    = op_done_out ? status_in : ~status_in;
  assign tag_present_out  = op_done_out ? present_in : ~present_in;
  assign tag_type_out     = op_done_out ? (status_in ^ 8'ha5) : status_in;
  assign tag_uid_out      = {10{op_status_out}};
  assign tag_uid_size_out = op_done_out ? 8'h07 : 8'hf8;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      run_q       <= 1'b0;
      cnt_q       <= 4'h0;
      op_done_out <= 1'b0;
    end else begin
      op_done_out <= run_q && (cnt_q == 4'h0);
      if (op_req_in) begin
        run_q <= 1'b1;
        cnt_q <= lat_in;
      end else if (run_q) begin
        run_q <= (cnt_q != 4'h0);
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // tcd_engine_model

// [dv/tcd_dispatch_tb_top.sv]
// self-checking bench of the tag command dispatcher
`timescale 1ns/1ps
`include "tcd_cmd_map.vh"
module tcd_dispatch_tb_top;
  reg         clk_in, rst_b_in, bus_sel_in, cmd_wr_in, i2c_stop_in, spi_cs_b_in;
  reg         pwd_wr_in, prot_acc_in, pres;
  reg  [7:0]  cmd_data_in, st;
  reg  [3:0]  lat;
  reg  [63:0] pwd_data_in, unlock_pwd_in, pw;
  wire        prot_deny_out, locked_out, op_req_out, op_done_in, tag_present_in;
  wire        nvm_commit_out, module_busy_low_out;
  wire [7:0]  op_code_out, op_status_in, tag_type_in, tag_uid_size_in;
  wire [7:0]  result_out, tag_type_out, tag_uid_size_out;
  wire [79:0] tag_uid_in, tag_uid_out;
  wire [6:0]  rgn_wr_out;
  wire [63:0] pwd_active_out;
  typedef struct {logic [7:0] res; logic [6:0] rgn; logic uid; logic [7:0] ty;
                  logic [7:0] sz; logic [79:0] id;} tcd_note_t;
  tcd_note_t   notes[$];
  tcd_note_t   cur;
  int          num_errors = 0;
  int          num_checks = 0;
  logic [15:0] lfsr_q = 16'h8f34;
  ////////////////////////////////////////////////////////////////////////////////
  tcd_dispatch tcd_dispatch_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_sel_in(bus_sel_in),
    .cmd_wr_in(cmd_wr_in), .cmd_data_in(cmd_data_in), .i2c_stop_in(i2c_stop_in),
    .spi_cs_b_in(spi_cs_b_in), .pwd_wr_in(pwd_wr_in), .pwd_data_in(pwd_data_in),
    .unlock_pwd_in(unlock_pwd_in), .prot_acc_in(prot_acc_in), .prot_deny_out(prot_deny_out),
    .locked_out(locked_out), .op_req_out(op_req_out), .op_code_out(op_code_out),
    .op_done_in(op_done_in), .op_status_in(op_status_in), .tag_present_in(tag_present_in),
    .tag_type_in(tag_type_in), .tag_uid_in(tag_uid_in), .tag_uid_size_in(tag_uid_size_in),
    .result_out(result_out), .tag_type_out(tag_type_out), .tag_uid_out(tag_uid_out),
    .tag_uid_size_out(tag_uid_size_out), .rgn_wr_out(rgn_wr_out),
    .nvm_commit_out(nvm_commit_out), .pwd_active_out(pwd_active_out),
    .module_busy_low_out(module_busy_low_out));
  tcd_engine_model tcd_engine_model_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .op_req_in(op_req_out), .lat_in(lat), .status_in(st), .present_in(pres),
    .op_done_out(op_done_in), .op_status_out(op_status_in), .tag_present_out(tag_present_in),
    .tag_type_out(tag_type_in), .tag_uid_out(tag_uid_in), .tag_uid_size_out(tag_uid_size_in));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction
  function automatic logic [6:0] exp_rgn(input logic [7:0] c);
    case (c)
      8'h01: return 7'h0f;
      8'h02, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h11, 8'h12, 8'h14, 8'h16,
      8'h17: return 7'h11;
      8'h19, 8'h1d: return 7'h10;
      8'h1a, 8'h1e: return 7'h41;
      8'h1c: return 7'h21;
      default: return 7'h01;
    endcase
  endfunction
  task check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task close_out;
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wait_busy(input logic v);
    int n;
    n = 0;
    while (module_busy_low_out !== v && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    check("busy", module_busy_low_out, v);
  endtask
  task run(input logic [7:0] c, input logic spi, input logic [7:0] res, input logic poke);
    logic [15:0] r;
    r = rnd();
    lat = {1'b0, r[2:0]};
    st = r[15:8];
    pres = r[4];
    notes.push_back('{(c > 8'h00 && c < 8'h1f && c != 8'h1b && c != 8'h1c) ? st : res,
                     exp_rgn(c), c == 8'h01, pres ? (st ^ 8'ha5) : 8'h00,
                     pres ? 8'h07 : 8'h00, {10{st}}});
    bus_sel_in = spi;
    spi_cs_b_in = !spi;
    if (spi) @(negedge clk_in);
    cmd_wr_in = 1'b1;
    cmd_data_in = c;
    i2c_stop_in = !spi;
    @(negedge clk_in);
    cmd_wr_in = 1'b0;
    i2c_stop_in = 1'b0;
    spi_cs_b_in = 1'b1;
    wait_busy(1'b0);
    cmd_wr_in = poke;
    cmd_data_in = 8'h1f;
    @(negedge clk_in);
    cmd_wr_in = 1'b0;
    wait_busy(1'b1);
    repeat (2) @(negedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    #1;
    if (rst_b_in && rgn_wr_out !== 7'h00) begin
      if (notes.size() == 0)
        check("stray update", rgn_wr_out, 7'h00);
      else begin
        cur = notes.pop_front();
        check("result", result_out, cur.res);
        check("regions", rgn_wr_out, cur.rgn);
        check("nvm commit", nvm_commit_out, cur.rgn[5]);
        if (cur.uid) begin
          check("tag type", tag_type_out, cur.ty);
          check("uid size", tag_uid_size_out, cur.sz);
          if (cur.sz != 8'h00)
            check("uid", tag_uid_out, cur.id);
        end
      end
    end
  end
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    #(25 * 30000);
    num_errors++;
    close_out();
  end
  initial begin
    {rst_b_in, bus_sel_in, cmd_wr_in, i2c_stop_in, pwd_wr_in, pres} = 6'h00;
    {cmd_data_in, st, lat, pwd_data_in, unlock_pwd_in} = '0;
    spi_cs_b_in = 1'b1;
    prot_acc_in = 1'b1;
    repeat (4) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (3) @(negedge clk_in);
    check("reset result", result_out, `TCD_RES_OK);
    check("reset deny", prot_deny_out, 1'b1);
    for (int c = 1; c < 8'h21; c++) begin
      if (c != 8'h1b && c != 8'h1c) begin
        run(c[7:0], lfsr_q[5], `TCD_RES_BAD_CMD, c == 8'h02);
        if (c < 8'h1f && st != `TCD_RES_OK)
          run(`TCD_CMD_GET_UID, lfsr_q[5], `TCD_RES_OK, 1'b0);
      end
    end
    run(`TCD_CMD_NOP, 1'b0, `TCD_RES_OK, 1'b0);
    run(8'hff, 1'b1, `TCD_RES_BAD_CMD, 1'b0);
    bus_sel_in = 1'b0;
    i2c_stop_in = 1'b1;
    @(negedge clk_in);
    i2c_stop_in = 1'b0;
    wait_busy(1'b0);
    wait_busy(1'b1);
    notes.push_back('{`TCD_RES_BAD_CMD, 7'h01, 1'b0, 8'h00, 8'h00, 80'h0});
    cmd_wr_in = 1'b1;
    cmd_data_in = 8'h1f;
    @(negedge clk_in);
    cmd_wr_in = 1'b0;
    repeat (4) @(negedge clk_in);
    check("no start", module_busy_low_out, 1'b1);
    i2c_stop_in = 1'b1;
    @(negedge clk_in);
    i2c_stop_in = 1'b0;
    wait_busy(1'b0);
    wait_busy(1'b1);
    unlock_pwd_in = 64'h1;
    run(`TCD_CMD_UNLOCK, 1'b0, `TCD_RES_BAD_PWD, 1'b0);
    check("locked", locked_out, 1'b1);
    unlock_pwd_in = 64'h0;
    run(`TCD_CMD_UNLOCK, 1'b1, `TCD_RES_OK, 1'b0);
    check("deny", prot_deny_out, 1'b0);
    pw = {rnd(), rnd(), rnd(), rnd()};
    pwd_data_in = pw;
    pwd_wr_in = 1'b1;
    @(negedge clk_in);
    pwd_wr_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check("password early", pwd_active_out, 64'h0);
    run(`TCD_CMD_LOCK, 1'b0, `TCD_RES_OK, 1'b0);
    check("password", pwd_active_out, pw);
    check("relocked", locked_out, 1'b1);
    prot_acc_in = 1'b0;
    @(negedge clk_in);
    check("deny idle", prot_deny_out, 1'b0);
    unlock_pwd_in = pw;
    run(`TCD_CMD_UNLOCK, 1'b0, `TCD_RES_OK, 1'b0);
    check("unlocked", locked_out, 1'b0);
    check("pending", notes.size(), 0);
    close_out();
  end
endmodule // tcd_dispatch_tb_top
